//--- dv/pin_source_model.sv
// Outside signal sources: capture pins, PWM pads and slow oscillator
`timescale 1ns/10ps
module pin_source_model (
  // Levels asked for by the bench
  input wire logic [1:0] cap_lvl_i,
  input wire logic [3:0] ext_lvl_i,
  // Pad drive from the timer block
  input wire logic [3:0] pin_drv_i,
  input wire logic [3:0] pin_oe_i,
  // Toward the timer block
  output logic cap_zero_o,
  output logic cap_one_o,
  output logic [3:0] pin_lvl_o,
  output logic osc_o
);
  // Edges land off the clock edge, as a real asynchronous source would
  assign #7 cap_zero_o = cap_lvl_i[0];
  assign #7 cap_one_o = cap_lvl_i[1];
  assign pin_lvl_o = (pin_oe_i & pin_drv_i) | (~pin_oe_i & ext_lvl_i);
  // Free running, phase unrelated to the system clock
  initial osc_o = 1'b0;
  always #103 osc_o = ~osc_o;
endmodule // pin_source_model

//--- dv/test_timers_capture_pwm_watchdog.sv
// Self-checking bench for the timer subsystem
`timescale 1ns/10ps
module test_timers_capture_pwm_watchdog;
  import timers_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic we_i = 1'b0;
  logic re_i = 1'b0;
  logic [31:0] rdata_o;
  logic cap0, cap1, osc, t24_irq_o, wd_rst_o;
  logic [3:0] pwm_i, pwm_o, pwm_oe_o, pwm_irq_o;
  logic [1:0] cap_lvl = 2'h0;
  logic [3:0] ext_lvl = 4'h0;
  int mismatches = 0;
  int checked = 0;
  int n, pre;
  logic [31:0] v, c1, c2;
  always #10 sys_clk_i = ~sys_clk_i;
  timers_capture_pwm_watchdog #(.WD_LIMIT(16'h0008)) u_timers_capture_pwm_watchdog (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
    .re_i(re_i), .rdata_o(rdata_o), .capture_pin_zero_i(cap0), .capture_pin_one_i(cap1),
    .pwm_i(pwm_i), .pwm_o(pwm_o), .pwm_oe_o(pwm_oe_o), .t24_irq_o(t24_irq_o),
    .pwm_irq_o(pwm_irq_o), .wd_osc_i(osc), .wd_rst_o(wd_rst_o));
  pin_source_model u_pin_source_model (.cap_lvl_i(cap_lvl), .ext_lvl_i(ext_lvl),
    .pin_drv_i(pwm_o), .pin_oe_i(pwm_oe_o), .cap_zero_o(cap0), .cap_one_o(cap1),
    .pin_lvl_o(pwm_i), .osc_o(osc));
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic give_up(input string nm);
    mismatches++;
    $display("wrong value %s expected done seen timeout", nm);
    tally_and_finish();
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    we_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    we_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    re_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    re_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  function automatic logic [31:0] t24w(input logic [7:0] pr, input logic [3:0] edg,
      input logic [1:0] upd, input logic [4:0] ie);
    return 32'h1 | (32'(pr) << PRE_LSB) | (32'(edg) << E0_LSB) | (32'(upd) << UPD_LSB)
      | (32'(ie) << T24_IE_LSB);
  endfunction
  function automatic logic [31:0] pwmw(input logic [1:0] a0, input logic [1:0] a1);
    return 32'h1 | (32'(RSRC_CMP) << RSRC_LSB) | (32'(a0) << ACT0_LSB)
      | (32'(a1) << ACT1_LSB) | (32'h2 << PWM_IE_LSB);
  endfunction
  task automatic edge_try(input int p, input logic lvl, input logic hit);
    logic [7:0] ca;
    logic [31:0] old, cap, a, b;
    ca = p ? T24_CAP1_ADDR : T24_CAP0_ADDR;
    rd(ca, old);
    rd(T24_CNT_ADDR, a);
    cap_lvl[p] <= lvl;
    repeat (6) @(posedge sys_clk_i);
    rd(T24_CNT_ADDR, b);
    rd(ca, cap);
    if (hit) chk("capture", 32'(cap >= a && cap <= b), 32'h1);
    else chk("capture kept", cap, old);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(73742));
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(T24_CMP0_ADDR, v);
    chk("t24 cmp0", v, {8'h00, CMP24_RST});
    rd(8'h44, v);
    chk("pwm cmp0", v, {16'h0, CMP16_RST});
    rd(8'h3c, v);
    chk("unmapped", v, 32'h0);
    rd(WD_STAT_ADDR, v);
    chk("wd off", v, 32'h0);
    pre = $urandom_range(7);
    wr(T24_CTRL_ADDR, t24w(8'(pre), 4'h0, UPD_NOW, 5'h0));
    rd(T24_CNT_ADDR, c1);
    repeat ((pre + 1) * 6 - 2) @(posedge sys_clk_i);
    rd(T24_CNT_ADDR, c2);
    chk("count step", c2 - c1, 32'h6);
    for (int p = 0; p < 2; p++) begin
      for (int m = 1; m < 4; m++) begin
        wr(T24_CTRL_ADDR, t24w(8'h00, 4'(m << (2 * p)), UPD_NOW, 5'h0));
        edge_try(p, 1'b1, m[0]);
        edge_try(p, 1'b0, m[1]);
      end
    end
    rd(T24_STAT_ADDR, v);
    chk("cap flags", v & 32'h6, 32'h6);
    chk("irq masked", 32'(t24_irq_o), 32'h0);
    wr(T24_CTRL_ADDR, t24w(8'h00, 4'h0, UPD_NOW, 5'h02));
    chk("irq cap0", 32'(t24_irq_o), 32'h1);
    wr(T24_STAT_ADDR, 32'h1f);
    chk("irq clear", 32'(t24_irq_o), 32'h0);
    $display("test capture done");
    rd(T24_CNT_ADDR, c1);
    wr(T24_CMP0_ADDR, c1 + 32'd40);
    wr(T24_CTRL_ADDR, t24w(8'h00, 4'h0, UPD_OWN, 5'h08));
    wr(T24_CMP0_ADDR, c1 + 32'd300);
    rd(T24_CMP0_ADDR, v);
    chk("active held", v, c1 + 32'd40);
    for (n = 0; n < 200 && t24_irq_o !== 1'b1; n++) begin
      @(posedge sys_clk_i);
      #1;
    end
    if (n == 200) give_up("compare irq");
    rd(T24_STAT_ADDR, v);
    chk("match flag", v & 32'h18, 32'h08);
    rd(T24_CMP0_ADDR, v);
    chk("shadow moved", v, c1 + 32'd300);
    $display("test compare done");
    for (int i = 0; i < 2; i++) begin
      wr(8'h44 + 8'(16 * i), 32'h4);
      wr(8'h48 + 8'(16 * i), 32'h9);
      wr(8'h40 + 8'(16 * i), i ? pwmw(ACT_TOGGLE, ACT_KEEP) : pwmw(ACT_HIGH, ACT_LOW));
      repeat (30) @(posedge sys_clk_i);
      c1 = 0;
      repeat (100) begin
        @(posedge sys_clk_i);
        #1 c1 += 32'(pwm_o[i]);
      end
      chk("pwm highs", c1, 32'd50);
      chk("pwm irq", 32'(pwm_irq_o), 32'(4'h3 >> (1 - i)));
    end
    v = 32'($urandom_range(1));
    ext_lvl[2] <= v[0];
    wr(8'h60, 32'h1 << GPIO_BIT);
    chk("pin oe", 32'(pwm_oe_o), 32'hb);
    repeat (3) @(posedge sys_clk_i);
    rd(8'h6c, c1);
    chk("pin level", (c1 >> 3) & 32'h1, v);
    wr(8'h70, 32'h1 | (32'h2 << RSRC_LSB));
    repeat (40) @(posedge sys_clk_i);
    wr(8'h70, 32'h1 | (32'h2 << RSRC_LSB) | (32'h1 << SWRST_BIT));
    rd(8'h7c, v);
    chk("sw reset", 32'(v[31:16] < 16'd5), 32'h1);
    $display("test pwm done");
    wr(WD_CTRL_ADDR, 32'h0);
    wr(WD_CTRL_ADDR, 32'h1);
    wr(WD_CTRL_ADDR, 32'h0);
    rd(WD_STAT_ADDR, v);
    chk("wd locked", v & 32'h2, 32'h2);
    repeat (20) begin
      wr(WD_KEY_ADDR, 32'h1);
      repeat (25) @(posedge sys_clk_i);
    end
    chk("wd serviced", 32'(wd_rst_o), 32'h0);
    v = 32'h0;
    for (n = 0; n < 100 && v[0] !== 1'b1; n++) rd(WD_STAT_ADDR, v);
    if (n == 100) give_up("wd half");
    chk("half first", 32'(wd_rst_o), 32'h0);
    for (n = 0; n < 300 && wd_rst_o !== 1'b1; n++) begin
      @(posedge sys_clk_i);
      #1;
    end
    if (n == 300) give_up("wd expiry");
    chk("slow ticks", 32'(n >= 25), 32'h1);
    rd(WD_STAT_ADDR, v);
    chk("wd status", v & 32'h4, 32'h4);
    $display("test watchdog done");
    tally_and_finish();
  end
endmodule // test_timers_capture_pwm_watchdog

//--- dv/timers_capture_pwm_watchdog_asserts.sv
// Port-level checker for the timer subsystem
`timescale 1ns/10ps
module timers_capture_pwm_watchdog_asserts
  import timers_pkg::*;
#(
  parameter int NPWM = 4
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic [31:0] rdata_o,
  // Pins
  input wire logic capture_pin_zero_i,
  input wire logic capture_pin_one_i,
  input wire logic [NPWM-1:0] pwm_i,
  input wire logic [NPWM-1:0] pwm_o,
  input wire logic [NPWM-1:0] pwm_oe_o,
  // Interrupts and watchdog
  input wire logic t24_irq_o,
  input wire logic [NPWM-1:0] pwm_irq_o,
  input wire logic wd_osc_i,
  input wire logic wd_rst_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  logic en_seen_q;
  logic [7:0] osc_hist_q;
  logic osc_rose;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_seen_q <= 1'b0;
      osc_hist_q <= 8'h00;
    end else begin
      en_seen_q <= en_seen_q | (we_i & (addr_i == WD_CTRL_ADDR) & wdata_i[0]);
      osc_hist_q <= {osc_hist_q[6:0], wd_osc_i};
    end
  end
  // Lenient window: any rising slow edge seen in the last eight cycles
  assign osc_rose = |(osc_hist_q[6:0] & ~osc_hist_q[7:1]);
  ////////////////////////////////////////////////////////////////////////////
  property p_wd_sticky;
    wd_rst_o |=> wd_rst_o;
  endproperty
  a_wd_sticky: assert property (p_wd_sticky) else $error("watchdog reset dropped");
  property p_wd_needs_en;
    $rose(wd_rst_o) |-> en_seen_q;
  endproperty
  a_wd_needs_en: assert property (p_wd_needs_en) else $error("reset while off");
  property p_wd_osc;
    $rose(wd_rst_o) |-> osc_rose;
  endproperty
  a_wd_osc: assert property (p_wd_osc) else $error("reset without slow tick");
  property p_wd_stat_rst;
    re_i && addr_i == WD_STAT_ADDR && wd_rst_o |=> rdata_o[2];
  endproperty
  a_wd_stat_rst: assert property (p_wd_stat_rst) else $error("reset status");
  property p_wd_stat_en;
    re_i && addr_i == WD_STAT_ADDR |=> rdata_o[1] == $past(en_seen_q);
  endproperty
  a_wd_stat_en: assert property (p_wd_stat_en) else $error("enable status");
  property p_t24_fall;
    $fell(t24_irq_o) |-> $past(we_i);
  endproperty
  a_t24_fall: assert property (p_t24_fall) else $error("timer irq fell alone");
  property p_pwm_fall;
    |($past(pwm_irq_o) & ~pwm_irq_o) |-> $past(we_i);
  endproperty
  a_pwm_fall: assert property (p_pwm_fall) else $error("pwm irq fell alone");
  property p_oe_write;
    pwm_oe_o != $past(pwm_oe_o) |-> $past(we_i) && $past(addr_i[7:6]) == PWM_BLK_SEL;
  endproperty
  a_oe_write: assert property (p_oe_write) else $error("pin enable moved");
  c_wd: cover property ($rose(wd_rst_o));
  c_t24: cover property ($rose(t24_irq_o));
  c_pwm: cover property ($rose(pwm_irq_o[0]));
endmodule // timers_capture_pwm_watchdog_asserts

bind timers_capture_pwm_watchdog timers_capture_pwm_watchdog_asserts #(.NPWM(NPWM)) u_asserts (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
  .re_i(re_i), .rdata_o(rdata_o), .capture_pin_zero_i(capture_pin_zero_i),
  .capture_pin_one_i(capture_pin_one_i), .pwm_i(pwm_i), .pwm_o(pwm_o), .pwm_oe_o(pwm_oe_o),
  .t24_irq_o(t24_irq_o), .pwm_irq_o(pwm_irq_o), .wd_osc_i(wd_osc_i), .wd_rst_o(wd_rst_o));

//--- src/timers_capture_pwm_watchdog.sv
// Capture/compare timer, four PWM timers and a watchdog behind a register port
//
// Overview of operation
// - One 24-bit up-counter on interface clock
// - 8-bit prescaler divides the 24-bit counter clock
// - Two compare registers, each match can interrupt
// - Compare writes shadowed, applied after match per mode
// - Capture edge select: rising, falling or both
// - Capture copies counter into its capture register
// - Overflow, two captures, two matches: separately enabled
// - Four 16-bit PWM counters, each 8-bit prescaler
// - Two PWM compares make set and unset events
// - PWM compare writes shadowed until match
// - PWM counter reset: rollover, compare or software
// - PWM overflow and two matches, separately enabled
// - Match drives pin high, low, toggle or keep
// - Pin level readable, pin usable as input
// - Watchdog counts low-speed oscillator ticks only
// - Watchdog expiry asserts processor reset
// - Watchdog starts disabled, software cannot disable
// - Half-timeout status flag for the watchdog
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/10ps
module timers_capture_pwm_watchdog
  import timers_pkg::*;
#(
  parameter int NPWM = 4,
  parameter int WD_W = 16,
  parameter logic [WD_W-1:0] WD_LIMIT = 16'hffff
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [31:0] rdata_o,
  // Capture pins
  input wire logic capture_pin_zero_i,
  input wire logic capture_pin_one_i,
  // PWM pins
  input wire logic [NPWM-1:0] pwm_i,
  output logic [NPWM-1:0] pwm_o,
  output logic [NPWM-1:0] pwm_oe_o,
  // Interrupt lines
  output logic t24_irq_o,
  output logic [NPWM-1:0] pwm_irq_o,
  // Watchdog
  input wire logic wd_osc_i,
  output logic wd_rst_o
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [31:0] ctrl;
    logic [7:0] pre;
    logic [15:0] cnt;
    logic [15:0] act0;
    logic [15:0] act1;
    logic [15:0] sh0;
    logic [15:0] sh1;
    logic ld0;
    logic ld1;
    logic [2:0] flg;
    logic out;
    logic [1:0] pin_s;
  } pwm_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [7:0] pre;
    logic [23:0] cnt;
    logic [23:0] act0;
    logic [23:0] act1;
    logic [23:0] sh0;
    logic [23:0] sh1;
    logic ld0;
    logic ld1;
    logic [23:0] cap0;
    logic [23:0] cap1;
    logic [4:0] flg;
    logic [2:0] cs0;
    logic [2:0] cs1;
    pwm_t [NPWM-1:0] pwm;
    logic wd_en;
    logic [WD_W-1:0] wd_cnt;
    logic wd_half;
    logic wd_rst;
    logic [2:0] wd_s;
    logic [31:0] rdata;
  } state_t;

  state_t q;
  state_t d;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic edge_hit(input logic [1:0] mode, input logic cur,
                                    input logic prev);
    return (mode[0] & cur & ~prev) | (mode[1] & ~cur & prev);
  endfunction

  function automatic logic pin_act(input logic [1:0] a, input logic v);
    logic r;
    r = v;
    case (a)
      ACT_KEEP: r = v;
      ACT_HIGH: r = 1'b1;
      ACT_LOW: r = 1'b0;
      ACT_TOGGLE: r = ~v;
      default: r = v;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic tk;
    logic m0;
    logic m1;
    logic ov;
    logic c0;
    logic c1;
    logic sel;
    logic [1:0] upd;
    logic [31:0] stat;
    tk = 1'b0;
    m0 = 1'b0;
    m1 = 1'b0;
    ov = 1'b0;
    c0 = 1'b0;
    c1 = 1'b0;
    sel = 1'b0;
    upd = 2'h0;
    stat = 32'h0;
    d = q;

    // 24-bit timer prescaler and counter
    // Reaching or passing the limit ticks, so a smaller prescale takes hold at once
    if (q.ctrl[EN_BIT]) begin
      if (q.pre >= q.ctrl[PRE_LSB +: 8]) begin
        d.pre = 8'h00;
        tk = 1'b1;
      end else begin
        d.pre = q.pre + 8'h01;
      end
    end else begin
      d.pre = 8'h00;
    end
    if (tk) begin
      d.cnt = q.cnt + 24'h000001;
    end
    ov = tk && (q.cnt == 24'hffffff);
    m0 = tk && (q.cnt == q.act0);
    m1 = tk && (q.cnt == q.act1);

    // Synchronise before edge detection; stages two and three feed the detector
    d.cs0 = {q.cs0[1], q.cs0[0], capture_pin_zero_i};
    d.cs1 = {q.cs1[1], q.cs1[0], capture_pin_one_i};
    c0 = edge_hit(q.ctrl[E0_LSB +: 2], q.cs0[1], q.cs0[2]);
    c1 = edge_hit(q.ctrl[E1_LSB +: 2], q.cs1[1], q.cs1[2]);
    if (c0) begin
      d.cap0 = q.cnt;
    end
    if (c1) begin
      d.cap1 = q.cnt;
    end

    // Pending shadow values move across after a match
    upd = q.ctrl[UPD_LSB +: 2];
    if (q.ld0 && ((m0 && upd == UPD_OWN) || ((m0 || m1) && upd == UPD_ANY))) begin
      d.act0 = q.sh0;
      d.ld0 = 1'b0;
    end
    if (q.ld1 && ((m1 && upd == UPD_OWN) || ((m0 || m1) && upd == UPD_ANY))) begin
      d.act1 = q.sh1;
      d.ld1 = 1'b0;
    end

    // Sticky flags: a write of one clears, a new event in the same cycle wins
    if (we_i && addr_i == T24_STAT_ADDR) begin
      d.flg = q.flg & ~wdata_i[4:0];
    end
    d.flg = d.flg | {m1, m0, c1, c0, ov};

    if (we_i) begin
      case (addr_i)
        T24_CTRL_ADDR: d.ctrl = wdata_i & T24_CTRL_MASK;
        T24_CMP0_ADDR: begin
          d.sh0 = wdata_i[23:0];
          d.ld0 = (upd != UPD_NOW);
          if (upd == UPD_NOW) begin
            d.act0 = wdata_i[23:0];
          end
        end
        T24_CMP1_ADDR: begin
          d.sh1 = wdata_i[23:0];
          d.ld1 = (upd != UPD_NOW);
          if (upd == UPD_NOW) begin
            d.act1 = wdata_i[23:0];
          end
        end
        default: ;
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // PWM timers
    for (int i = 0; i < NPWM; i++) begin
      tk = 1'b0;
      sel = we_i && addr_i[7:6] == PWM_BLK_SEL && addr_i[5:4] == i[1:0];
      d.pwm[i].pin_s = {q.pwm[i].pin_s[0], pwm_i[i]};
      if (q.pwm[i].ctrl[EN_BIT]) begin
        if (q.pwm[i].pre >= q.pwm[i].ctrl[PRE_LSB +: 8]) begin
          d.pwm[i].pre = 8'h00;
          tk = 1'b1;
        end else begin
          d.pwm[i].pre = q.pwm[i].pre + 8'h01;
        end
      end else begin
        d.pwm[i].pre = 8'h00;
      end
      m0 = tk && (q.pwm[i].cnt == q.pwm[i].act0);
      m1 = tk && (q.pwm[i].cnt == q.pwm[i].act1);
      ov = 1'b0;
      if (tk) begin
        if (q.pwm[i].ctrl[RSRC_LSB +: 2] == RSRC_CMP && m1) begin
          d.pwm[i].cnt = 16'h0000;
        end else if (q.pwm[i].cnt != 16'hffff) begin
          d.pwm[i].cnt = q.pwm[i].cnt + 16'h0001;
        end else if (!q.pwm[i].ctrl[RSRC_LSB + 1]) begin
          // Rollover and compare sources wrap to zero here with overflow; software-only parks at the top until the reset bit is written
          d.pwm[i].cnt = 16'h0000;
          ov = 1'b1;
        end
      end
      if (m0) begin
        d.pwm[i].out = pin_act(q.pwm[i].ctrl[ACT0_LSB +: 2], q.pwm[i].out);
      end
      if (m1) begin
        // Unset event has the last word when both match at once
        d.pwm[i].out = pin_act(q.pwm[i].ctrl[ACT1_LSB +: 2], d.pwm[i].out);
      end
      upd = q.pwm[i].ctrl[PWM_UPD_LSB +: 2];
      if (q.pwm[i].ld0 && ((m0 && upd == UPD_OWN) || ((m0 || m1) && upd == UPD_ANY))) begin
        d.pwm[i].act0 = q.pwm[i].sh0;
        d.pwm[i].ld0 = 1'b0;
      end
      if (q.pwm[i].ld1 && ((m1 && upd == UPD_OWN) || ((m0 || m1) && upd == UPD_ANY))) begin
        d.pwm[i].act1 = q.pwm[i].sh1;
        d.pwm[i].ld1 = 1'b0;
      end
      if (sel && addr_i[3:2] == PWM_STAT_OFS) begin
        d.pwm[i].flg = q.pwm[i].flg & ~wdata_i[2:0];
      end
      d.pwm[i].flg = d.pwm[i].flg | {m1, m0, ov};
      if (sel) begin
        case (addr_i[3:2])
          PWM_CTRL_OFS: begin
            d.pwm[i].ctrl = wdata_i & PWM_CTRL_MASK;
            if (wdata_i[SWRST_BIT]) begin
              d.pwm[i].cnt = 16'h0000;
              d.pwm[i].pre = 8'h00;
            end
          end
          PWM_CMP0_OFS: begin
            d.pwm[i].sh0 = wdata_i[15:0];
            d.pwm[i].ld0 = (upd != UPD_NOW);
            if (upd == UPD_NOW) begin
              d.pwm[i].act0 = wdata_i[15:0];
            end
          end
          PWM_CMP1_OFS: begin
            d.pwm[i].sh1 = wdata_i[15:0];
            d.pwm[i].ld1 = (upd != UPD_NOW);
            if (upd == UPD_NOW) begin
              d.pwm[i].act1 = wdata_i[15:0];
            end
          end
          default: ;
        endcase
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // Watchdog: oscillator is slow, so its rising edge becomes a tick here
    d.wd_s = {q.wd_s[1], q.wd_s[0], wd_osc_i};
    tk = q.wd_s[1] & ~q.wd_s[2];
    if (we_i && addr_i == WD_CTRL_ADDR && wdata_i[0]) begin
      d.wd_en = 1'b1;
    end
    if (we_i && addr_i == WD_KEY_ADDR && wdata_i[0]) begin
      d.wd_cnt = '0;
      d.wd_half = 1'b0;
    end else if (q.wd_en && tk) begin
      if (q.wd_cnt == WD_LIMIT) begin
        d.wd_rst = 1'b1;
      end else begin
        d.wd_cnt = q.wd_cnt + 1'b1;
      end
      if (q.wd_cnt == (WD_LIMIT >> 1)) begin
        d.wd_half = 1'b1;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // Read data, valid in the cycle after the strobe only
    d.rdata = 32'h0;
    if (re_i) begin
      if (addr_i[7:6] == PWM_BLK_SEL && addr_i[5:4] < NPWM) begin
        for (int i = 0; i < NPWM; i++) begin
          if (addr_i[5:4] == i[1:0]) begin
            stat = {q.pwm[i].cnt, 12'h000, q.pwm[i].pin_s[1], q.pwm[i].flg};
            case (addr_i[3:2])
              PWM_CTRL_OFS: d.rdata = q.pwm[i].ctrl;
              PWM_CMP0_OFS: d.rdata = {16'h0000, q.pwm[i].act0};
              PWM_CMP1_OFS: d.rdata = {16'h0000, q.pwm[i].act1};
              PWM_STAT_OFS: d.rdata = stat;
              default: d.rdata = 32'h0;
            endcase
          end
        end
      end else begin
        case (addr_i)
          T24_CTRL_ADDR: d.rdata = q.ctrl;
          T24_CNT_ADDR: d.rdata = {8'h00, q.cnt};
          T24_CMP0_ADDR: d.rdata = {8'h00, q.act0};
          T24_CMP1_ADDR: d.rdata = {8'h00, q.act1};
          T24_CAP0_ADDR: d.rdata = {8'h00, q.cap0};
          T24_CAP1_ADDR: d.rdata = {8'h00, q.cap1};
          T24_STAT_ADDR: d.rdata = {27'h0, q.flg};
          WD_CTRL_ADDR: d.rdata = {31'h0, q.wd_en};
          WD_STAT_ADDR: d.rdata = {29'h0, q.wd_rst, q.wd_en, q.wd_half};
          default: d.rdata = 32'h0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.act0 <= CMP24_RST;
      q.act1 <= CMP24_RST;
      q.ctrl <= CTRL_RST;
      for (int i = 0; i < NPWM; i++) begin
        q.pwm[i].act0 <= CMP16_RST;
        q.pwm[i].act1 <= CMP16_RST;
      end
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rdata_o = q.rdata;
    wd_rst_o = q.wd_rst;
    t24_irq_o = |(q.flg & q.ctrl[T24_IE_LSB +: 5]);
    for (int i = 0; i < NPWM; i++) begin
      pwm_o[i] = q.pwm[i].out;
      pwm_oe_o[i] = ~q.pwm[i].ctrl[GPIO_BIT];
      pwm_irq_o[i] = |(q.pwm[i].flg & q.pwm[i].ctrl[PWM_IE_LSB +: 3]);
    end
  end

endmodule // timers_capture_pwm_watchdog

//--- src/timers_pkg.sv
// Register map, field positions and reset values for the timer subsystem
package timers_pkg;
  // 24-bit timer registers
  localparam logic [7:0] T24_CTRL_ADDR = 8'h00;
  localparam logic [7:0] T24_CNT_ADDR = 8'h04;
  localparam logic [7:0] T24_CMP0_ADDR = 8'h08;
  localparam logic [7:0] T24_CMP1_ADDR = 8'h0c;
  localparam logic [7:0] T24_CAP0_ADDR = 8'h10;
  localparam logic [7:0] T24_CAP1_ADDR = 8'h14;
  localparam logic [7:0] T24_STAT_ADDR = 8'h18;
  // PWM timers: base plus stride times index, word offsets inside
  localparam logic [1:0] PWM_BLK_SEL = 2'h1;
  localparam logic [1:0] PWM_CTRL_OFS = 2'h0;
  localparam logic [1:0] PWM_CMP0_OFS = 2'h1;
  localparam logic [1:0] PWM_CMP1_OFS = 2'h2;
  localparam logic [1:0] PWM_STAT_OFS = 2'h3;
  // Watchdog registers
  localparam logic [7:0] WD_CTRL_ADDR = 8'h80;
  localparam logic [7:0] WD_KEY_ADDR = 8'h84;
  localparam logic [7:0] WD_STAT_ADDR = 8'h88;
  // Control field positions; enable and prescale shared by both timer kinds
  localparam int EN_BIT = 0;
  localparam int PRE_LSB = 8;
  localparam int E0_LSB = 16;
  localparam int E1_LSB = 18;
  localparam int UPD_LSB = 20;
  localparam int T24_IE_LSB = 22;
  localparam int RSRC_LSB = 16;
  localparam int SWRST_BIT = 18;
  localparam int ACT0_LSB = 19;
  localparam int ACT1_LSB = 21;
  localparam int GPIO_BIT = 23;
  localparam int PWM_IE_LSB = 24;
  localparam int PWM_UPD_LSB = 27;
  // Writable bits of each control word; the rest read as zero
  localparam logic [31:0] T24_CTRL_MASK = 32'h07ffff01;
  localparam logic [31:0] PWM_CTRL_MASK = 32'h1ffbff01;
  // Values after reset
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [23:0] CMP24_RST = 24'hffffff;
  localparam logic [15:0] CMP16_RST = 16'hffff;
  // Shadow update modes
  localparam logic [1:0] UPD_NOW = 2'h0;
  localparam logic [1:0] UPD_OWN = 2'h1;
  localparam logic [1:0] UPD_ANY = 2'h2;
  // Counter reset sources
  localparam logic [1:0] RSRC_ROLL = 2'h0;
  localparam logic [1:0] RSRC_CMP = 2'h1;
  // Pin actions
  localparam logic [1:0] ACT_KEEP = 2'h0;
  localparam logic [1:0] ACT_HIGH = 2'h1;
  localparam logic [1:0] ACT_LOW = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
endpackage
